// File: sec_pkg.sv
// Package of constants for the serial EEPROM command front end
package sec_pkg;
    // ************************************************************
    // Op-codes
    // ************************************************************
    localparam logic [7:0] SEC_OP_SET_LATCH = 8'h06;
    localparam logic [7:0] SEC_OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] SEC_OP_RD_STATUS = 8'h05;
    localparam logic [7:0] SEC_OP_WR_STATUS = 8'h01;
    localparam logic [7:0] SEC_OP_READ = 8'h03;
    localparam logic [7:0] SEC_OP_WRITE = 8'h02;
    // ************************************************************
    // Status register field positions and reset value
    // ************************************************************
    localparam int SEC_SR_BUSY = 0;
    localparam int SEC_SR_LATCH = 1;
    localparam int SEC_SR_BP0 = 2;
    localparam int SEC_SR_BP1 = 3;
    localparam int SEC_SR_LOCK = 4;
    localparam int SEC_SR_IDSEL = 6;
    localparam int SEC_SR_PPEN = 7;
    localparam logic [7:0] SEC_SR_RESET = 8'h00;
    // ************************************************************
    // Sizes and timing
    // ************************************************************
    localparam int SEC_ARRAY_BYTES = 8192;
    localparam int SEC_ID_BYTES = 32;
    localparam int SEC_ADDR_BITS = 13;
    localparam int SEC_CLK_HZ = 40000000;
    localparam int SEC_TWC_US = 4000;
    // Longest time rounds down
    localparam int SEC_TWC_CYC = (SEC_CLK_HZ / 1000) * SEC_TWC_US / 1000;
    localparam int SEC_CNT_W = 24;
endpackage : sec_pkg

// File: sec_eeprom_cmd.sv
// SPI EEPROM command front end sampled on the system clock
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Serial input is sampled on every rising serial clock edge, modes 0 and 3.
// - Serial output changes only on falling serial clock edges.
// - Clock may idle low or high; both modes work alike.
// - Select high tristates output and idles; a running write still completes.
// - Protect pin high places no restriction on writes.
// - Protect pin low with pin-enable bit set refuses status writes.
// - After a pause the transaction resumes where it stopped.
// - Output released while paused and driven again afterwards.
// - First byte after select falls goes into an 8-bit instruction register.
// - Only six op-codes act; others are silently ignored.
// - Set latch is 06h, clear latch is 04h.
// - Read status is 05h, write status is 01h.
// - Memory read op-code is 03h.
// - Memory write op-code is 02h.
// - Read op-code plus address returns stored data.
// - Id-page select bit set makes reads and writes use a 32-byte page.
// - Lock bit makes the id page read-only until the next reset; no status write clears it.
// - Self-timed write starts at select rising, finishes within 4 ms.
// - Busy bit reads 1 during write cycle, 0 otherwise, not host writable.
// - Set-latch sets the latch bit, clear-latch clears it.
// - Memory write is op-code, 16-bit address, data, one select session.
// - During a write cycle only the status read is obeyed.
module sec_eeprom_cmd
    import sec_pkg::*;
#(
    parameter int TWC_CYCLES = SEC_TWC_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic CS_B,
    input wire logic SCK,
    input wire logic SI,
    input wire logic PAUSE_B,
    input wire logic WP_B,
    output logic SO,
    output logic SO_OE,
    output logic BUSY
);
    typedef enum logic [3:0] {
        SEC_OP = 4'b0001,
        SEC_ADR = 4'b0010,
        SEC_DAT = 4'b0100,
        SEC_IGN = 4'b1000
    } sec_phase_t;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [1:0] cs_s, sck_s, si_s, hold_s, wp_s;
    logic sck_d;
    // Two flops per pin, first flop read only by second
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            cs_s <= 2'b11;
            sck_s <= 2'b00;
            si_s <= 2'b00;
            hold_s <= 2'b11;
            wp_s <= 2'b11;
            sck_d <= 1'b0;
        end else begin
            cs_s <= {cs_s[0], CS_B};
            sck_s <= {sck_s[0], SCK};
            si_s <= {si_s[0], SI};
            hold_s <= {hold_s[0], PAUSE_B};
            wp_s <= {wp_s[0], WP_B};
            sck_d <= sck_s[1];
        end
    end

    logic cs_n, hold_n, wp_n, sck_rise, sck_fall, active;
    assign cs_n = cs_s[1];
    assign hold_n = hold_s[1];
    assign wp_n = wp_s[1];
    // Edges only count while selected and not paused
    assign active = !cs_n && hold_n;
    assign sck_rise = active && sck_s[1] && !sck_d;
    assign sck_fall = active && !sck_s[1] && sck_d;

    // ************************************************************
    // Storage and state
    // ************************************************************
    logic [7:0] mem [SEC_ARRAY_BYTES];
    logic [7:0] idp [SEC_ID_BYTES];
    logic [7:0] buf_data [SEC_ID_BYTES];
    logic [4:0] buf_cnt;
    logic [4:0] buf_start;
    logic [15:0] addr;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [7:0] opcode;
    sec_phase_t phase;
    logic [4:0] adr_bytes;
    logic latch, ppen, idsel, lock, bp0, bp1;
    logic busy;
    logic [SEC_CNT_W-1:0] wcnt;
    logic cs_d;
    logic [7:0] out_byte;
    logic so_q;
    logic pend_mem, pend_sr;
    logic [7:0] pend_srv;
    logic [7:0] status;

    assign status = {ppen, idsel, 1'b0, lock, bp1, bp0, latch, busy};

    logic byte_done;
    assign byte_done = sck_rise && (bitcnt == 3'd7);
    logic [7:0] rx_byte;
    assign rx_byte = {shreg[6:0], si_s[1]};

    // Write-protect decision for the status register
    logic sr_locked;
    assign sr_locked = ppen && !wp_n;

    // Protected region by block bits (upper address bits)
    function automatic logic prot(input logic [12:0] a, input logic b1, input logic b0);
        logic p;
        p = 1'b0;
        case ({b1, b0})
            2'b01: p = (a[12:11] == 2'b11);
            2'b10: p = a[12];
            2'b11: p = 1'b1;
            default: p = 1'b0;
        endcase
        return p;
    endfunction

    // ************************************************************
    // Bit and byte sequencer
    // ************************************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B || cs_n) begin
            shreg <= 8'h00;
            bitcnt <= 3'd0;
        end else if (sck_rise) begin
            shreg <= rx_byte;
            bitcnt <= bitcnt + 3'd1;
        end
    end

    // Phase machine: op-code, address, data
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B || cs_n) begin
            phase <= SEC_OP;
            opcode <= 8'h00;
            adr_bytes <= 5'd0;
        end else if (byte_done) begin
            case (phase)
                SEC_OP: begin
                    opcode <= rx_byte;
                    buf_cnt <= 5'd0; // Count and address outlive select rise for the launch
                    // While busy only status read is obeyed
                    if (busy && rx_byte != SEC_OP_RD_STATUS) begin
                        phase <= SEC_IGN;
                    end else if (rx_byte == SEC_OP_READ || rx_byte == SEC_OP_WRITE) begin
                        phase <= SEC_ADR;
                    end else if (rx_byte == SEC_OP_RD_STATUS || rx_byte == SEC_OP_WR_STATUS
                        || rx_byte == SEC_OP_SET_LATCH || rx_byte == SEC_OP_CLR_LATCH) begin
                        phase <= SEC_DAT;
                    end else begin
                        phase <= SEC_IGN;
                    end
                end
                SEC_ADR: begin
                    addr <= {addr[7:0], rx_byte};
                    adr_bytes <= adr_bytes + 5'd1;
                    if (adr_bytes == 5'd1) begin
                        phase <= SEC_DAT;
                    end
                end
                SEC_DAT: begin
                    if (opcode == SEC_OP_WRITE) begin
                        buf_data[buf_cnt] <= rx_byte;
                        buf_cnt <= buf_cnt + 5'd1;
                    end
                    if (opcode == SEC_OP_READ) begin
                        addr <= addr + 16'h0001;
                    end
                end
                default: phase <= SEC_IGN;
            endcase
        end
    end

    // ************************************************************
    // Output shifter, updated on falling edges
    // ************************************************************
    assign out_byte = (opcode == SEC_OP_RD_STATUS) ? status
        : (idsel ? idp[addr[4:0]] : mem[addr[12:0]]);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B || cs_n) begin
            so_q <= 1'b0;
        end else if (sck_fall && phase == SEC_DAT
                     && (opcode == SEC_OP_READ || opcode == SEC_OP_RD_STATUS)) begin
            so_q <= out_byte[3'd7 - bitcnt];
        end
    end
    assign SO = so_q;
    assign SO_OE = active;
    assign BUSY = busy;

    // ************************************************************
    // Session end: latch commands and write launch
    // ************************************************************
    logic sess_end, op_ok;
    assign sess_end = cs_n && !cs_d;
    assign op_ok = (phase == SEC_DAT) && (bitcnt == 3'd0);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            cs_d <= 1'b1;
        end else begin
            cs_d <= cs_n;
        end
    end

    // Status bits, latch, pending write and self-timer
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            latch <= SEC_SR_RESET[SEC_SR_LATCH];
            ppen <= SEC_SR_RESET[SEC_SR_PPEN];
            idsel <= SEC_SR_RESET[SEC_SR_IDSEL];
            lock <= SEC_SR_RESET[SEC_SR_LOCK];
            bp0 <= SEC_SR_RESET[SEC_SR_BP0];
            bp1 <= SEC_SR_RESET[SEC_SR_BP1];
            busy <= 1'b0;
            wcnt <= '0;
            pend_mem <= 1'b0;
            pend_sr <= 1'b0;
            pend_srv <= 8'h00;
            buf_start <= 5'd0;
        end else if (busy) begin
            // Timer runs regardless of select
            if (wcnt == SEC_CNT_W'(TWC_CYCLES - 1)) begin
                busy <= 1'b0;
                latch <= 1'b0;
                if (pend_sr) begin
                    ppen <= pend_srv[SEC_SR_PPEN];
                    bp1 <= pend_srv[SEC_SR_BP1];
                    bp0 <= pend_srv[SEC_SR_BP0];
                    if (!(pend_srv[SEC_SR_IDSEL] && pend_srv[SEC_SR_LOCK])) begin
                        idsel <= pend_srv[SEC_SR_IDSEL];
                        lock <= lock | pend_srv[SEC_SR_LOCK];
                    end
                end
                if (pend_mem) begin
                    idsel <= 1'b0;
                end
                pend_mem <= 1'b0;
                pend_sr <= 1'b0;
            end
            wcnt <= wcnt + SEC_CNT_W'(1);
        end else if (sess_end && op_ok) begin
            case (opcode)
                SEC_OP_SET_LATCH: latch <= 1'b1;
                SEC_OP_CLR_LATCH: latch <= 1'b0;
                SEC_OP_WR_STATUS: begin
                    if (latch && !sr_locked && buf_cnt == 5'd0) begin
                        pend_sr <= 1'b1;
                        pend_srv <= shreg;
                        busy <= 1'b1;
                        wcnt <= '0;
                    end
                end
                SEC_OP_WRITE: begin
                    if (latch && buf_cnt != 5'd0
                        && !prot(addr[12:0], bp1, bp0)
                        && !(idsel && lock)) begin
                        pend_mem <= 1'b1;
                        buf_start <= addr[4:0];
                        busy <= 1'b1;
                        wcnt <= '0;
                    end
                end
                SEC_OP_READ: idsel <= 1'b0;
                default: latch <= latch;
            endcase
        end
    end

    // Array programming at the start of the self-timed cycle
    always_ff @(posedge SYS_CLK) begin
        if (busy && pend_mem && wcnt == '0) begin
            for (int i = 0; i < SEC_ID_BYTES; i++) begin
                if (5'(i) < buf_cnt) begin
                    if (idsel) begin
                        idp[5'(buf_start + 5'(i))] <= buf_data[i];
                    end else begin
                        mem[{addr[12:5], 5'(buf_start + 5'(i))}] <= buf_data[i];
                    end
                end
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_busy_bound: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        busy |-> wcnt < SEC_CNT_W'(TWC_CYCLES))
        else $error("write cycle overran");
    a_busy_start: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        $rose(busy) |-> $past(sess_end))
        else $error("write began without select rising");
    a_so_release: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        ($past(CS_B, 2) || !$past(PAUSE_B, 2)) |-> !SO_OE)
        else $error("output driven while idle or paused");
    a_so_fall: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (!cs_n && $changed(so_q)) |-> $past(sck_fall))
        else $error("output changed off a falling edge");
    a_shift_rise: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (!cs_n && !$past(cs_n) && $changed(bitcnt)) |-> $past(sck_rise))
        else $error("input sampled off a rising edge");
    a_sr_guard: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        $rose(pend_sr) |-> !$past(sr_locked))
        else $error("status written while pin protected");
    a_latch_set: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (sess_end && op_ok && !busy && opcode == SEC_OP_SET_LATCH) |=> latch)
        else $error("latch not set");
    a_busy_ignore: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        (busy && byte_done && phase == SEC_OP && rx_byte != SEC_OP_RD_STATUS)
        |=> phase == SEC_IGN)
        else $error("command obeyed while busy");
    a_lock_wr: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        $rose(pend_mem) |-> !($past(idsel) && $past(lock)))
        else $error("locked id page written");
endmodule : sec_eeprom_cmd

`default_nettype wire

// File: sec_host_model.sv
// Host SPI controller model driving the serial pins of the EEPROM front end
`timescale 1ns/1ps
`default_nettype none
module sec_host_model (
    input wire logic clk,
    input wire logic miso,
    output logic cs_b,
    output logic sck,
    output logic mosi,
    output logic pause_b,
    output logic rx_done,
    output logic [7:0] rx_data
);
    logic mode3;
    // ********************
    // Idle pin levels
    // ********************
    initial begin
        cs_b = 1'b1;
        sck = 1'b0;
        mosi = 1'b1;
        pause_b = 1'b1;
        rx_done = 1'b0;
        rx_data = 8'h00;
        mode3 = 1'b0;
    end
    // ********************
    // Pin sequences
    // ********************
    // Half a serial period, launched just after a system edge
    task automatic half;
        repeat (4) @(posedge clk);
        #2;
    endtask : half
    // Parks the clock at the mode's idle level, then selects
    task automatic open_s(input logic m3);
        mode3 = m3;
        sck = m3;
        half();
        cs_b = 1'b0;
        half();
    endtask : open_s
    // Returns the clock to idle, deselects, then spoils the data line
    task automatic close_s;
        sck = mode3;
        half();
        cs_b = 1'b1;
        mosi = ~mosi;
        half();
    endtask : close_s
    // One byte each way; data set while clock low, read before it rises
    task automatic xfer(input logic [7:0] tx, input logic keep);
        logic [7:0] rx;
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            mosi = tx[i];
            half();
            rx[i] = miso;
            sck = 1'b1;
            half();
        end
        if (keep) begin
            rx_data = rx;
            rx_done = 1'b1;
            @(posedge clk);
            #2;
            rx_done = 1'b0;
        end
    endtask : xfer
    // Moves the pause pin with the clock held low
    task automatic pause_set(input logic v);
        sck = 1'b0;
        half();
        pause_b = v;
        half();
    endtask : pause_set
endmodule : sec_host_model
`default_nettype wire

// File: tb_sec_eeprom_cmd.sv
// Self-checking bench for the serial EEPROM command front end
`timescale 1ns/1ps
`default_nettype none
module tb_sec_eeprom_cmd;
    import sec_pkg::*;
    localparam int TWC = 400;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wp_b = 1'b1;
    logic cs_b, sck, si, pause_b, so, so_oe, busy, rx_done, miso;
    logic [7:0] rx_data;
    logic [15:0] lfsr = 16'hA8F1; // Seed 43249
    logic [15:0] a;
    logic [7:0] d;
    logic [7:0] exp_q[$];
    logic [7:0] msk_q[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int run = 0;
    int last_run = 0;
    // ********************
    // Clock and instances
    // ********************
    always #12.5 sys_clk = ~sys_clk;
    assign miso = so_oe ? so : 1'b1; // Pull-up on the released line
    sec_eeprom_cmd #(.TWC_CYCLES(TWC)) dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .CS_B(cs_b),
        .SCK(sck), .SI(si), .PAUSE_B(pause_b), .WP_B(wp_b), .SO(so), .SO_OE(so_oe),
        .BUSY(busy));
    sec_host_model host (.clk(sys_clk), .miso(miso), .cs_b(cs_b), .sck(sck), .mosi(si),
        .pause_b(pause_b), .rx_done(rx_done), .rx_data(rx_data));
    // ********************
    // Checking
    // ********************
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Oldest note is compared with every byte the host keeps
    always @(posedge rx_done) begin
        if (exp_q.size() == 0) begin
            chk("unexpected byte", 8'h00, 8'hFF);
        end else begin
            chk("read byte", rx_data & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    // Length of the last busy stretch in system clocks
    always @(posedge sys_clk) begin
        if (busy === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            last_run <= run;
            run <= 0;
        end
    end
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    // ********************
    // Command sessions
    // ********************
    task automatic op_only(input logic [7:0] op);
        host.open_s(1'b0);
        host.xfer(op, 1'b0);
        host.close_s();
    endtask : op_only
    task automatic rd_status(input logic [7:0] e, input logic [7:0] m);
        host.open_s(1'b1);
        host.xfer(SEC_OP_RD_STATUS, 1'b0);
        exp_q.push_back(e);
        msk_q.push_back(m);
        host.xfer(8'h00, 1'b1);
        host.close_s();
        chk("output enable deselected", {7'h00, so_oe}, 8'h00);
    endtask : rd_status
    task automatic wait_idle;
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge sys_clk);
        #2;
    endtask : wait_idle
    task automatic wr_status(input logic [7:0] v);
        op_only(SEC_OP_SET_LATCH);
        host.open_s(1'b0);
        host.xfer(SEC_OP_WR_STATUS, 1'b0);
        host.xfer(v, 1'b0);
        host.close_s();
        wait_idle();
    endtask : wr_status
    task automatic mem_write(input logic [15:0] wa, input logic [7:0] wd);
        op_only(SEC_OP_SET_LATCH);
        host.open_s(1'b0);
        host.xfer(SEC_OP_WRITE, 1'b0);
        host.xfer(wa[15:8], 1'b0);
        host.xfer(wa[7:0], 1'b0);
        host.xfer(wd, 1'b0);
        host.close_s();
    endtask : mem_write
    task automatic mem_read(input logic m3, input logic [15:0] ra, input logic [7:0] rd,
        input logic hold);
        host.open_s(m3);
        host.xfer(SEC_OP_READ, 1'b0);
        host.xfer(ra[15:8], 1'b0);
        if (hold) begin
            host.pause_set(1'b0);
            chk("output enable paused", {7'h00, so_oe}, 8'h00);
            host.pause_set(1'b1);
            chk("output enable resumed", {7'h00, so_oe}, 8'h01);
        end
        host.xfer(ra[7:0], 1'b0);
        exp_q.push_back(rd);
        msk_q.push_back(8'hFF);
        host.xfer(8'h00, 1'b1);
        host.close_s();
    endtask : mem_read
    // ********************
    // Main sequence
    // ********************
    initial begin
        repeat (16) @(posedge sys_clk);
        #2;
        rst_b = 1'b1;
        repeat (14000) @(posedge sys_clk); // Power-up wait of 0.35 ms
        rd_status(SEC_SR_RESET, 8'hFF);
        op_only(SEC_OP_SET_LATCH);
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            op_only({1'b1, lfsr[6:0]});
        end
        rd_status(8'h02, 8'hFF);
        op_only(SEC_OP_CLR_LATCH);
        rd_status(8'h00, 8'hFF);
        $display("test op-codes done");
        for (int k = 0; k < 3; k++) begin
            lfsr = lfsr_next(lfsr);
            a = lfsr;
            lfsr = lfsr_next(lfsr);
            d = lfsr[7:0];
            wp_b = lfsr[8];
            mem_write(a, d);
            chk("busy after select rise", {7'h00, busy}, 8'h01);
            rd_status(8'h01, 8'h01);
            op_only(SEC_OP_SET_LATCH);
            wait_idle();
            repeat (2) @(posedge sys_clk);
            #2;
            chk("write cycle length", {7'h00, last_run == TWC}, 8'h01);
            rd_status(8'h00, 8'hFF);
            mem_read(k[0], a, d, k == 2 || lfsr[9]);
        end
        $display("test array done");
        wp_b = 1'b1;
        wr_status(8'h80);
        rd_status(8'h80, 8'hFC);
        wp_b = 1'b0;
        wr_status(8'h8C);
        rd_status(8'h80, 8'hFC);
        wp_b = 1'b1;
        wr_status(8'h00);
        rd_status(8'h00, 8'hFC);
        $display("test protect pin done");
        wr_status(8'h40);
        mem_write(16'h0005, d);
        wait_idle();
        wr_status(8'h40);
        mem_read(1'b0, 16'h0005, d, 1'b0);
        wr_status(8'h10);
        wr_status(8'h40);
        mem_write(16'h0005, ~d);
        wait_idle();
        wr_status(8'h40);
        mem_read(1'b1, 16'h0005, d, 1'b0);
        $display("test id page done");
        chk("pending notes", 8'(exp_q.size()), 8'h00);
        close_out();
    end
    // Watchdog at about three times the expected run of 0.65 ms
    initial begin
        #2000000;
        n_mismatch++;
        close_out();
    end
endmodule : tb_sec_eeprom_cmd
`default_nettype wire
